// ---- frb_bank.sv ----
// fan ramp, boost, smoothing, table, open-drain and throttle setup bank
`timescale 1ns/100ps
// ------------------------------------------------------------
// What this block does
// - low nibble sets regulator-hot ramp step interval
// - high nibble sets processor-hot ramp step interval
// - step interval is code times 50 ms
// - zero interval code jumps straight to full
// - boost holds full until temp falls below threshold less hysteresis
// - hysteresis nibbles: zones one and two
// - hysteresis nibbles: zones three and four
// - zone one enable picks filtered temperature
// - zone two enable picks filtered temperature
// - readings stay raw, filtered always kept
// - window codes select 11.8 to 0.4 seconds
// - pair a hysteresis, resolution from bit 4
// - pair b hysteresis, resolution from bit 5
// - high nibble gives minimum duty, 13 mapped
// - set bit pulls its pin low
// - force bit throttles at selected duty
// - disable bit blocks regulator-hot to throttle
// - inputs eight and nine levels only legacy mode
// - throttle period 80 ticks, on (code+1)*5
// - legacy mode is mode field zero
// ------------------------------------------------------------
module frb_bank #(
  parameter int RAMP_UNIT_CYCLES = frb_pkg::RAMP_UNIT_CYCLES, // 50 ms
  // throttle tick divider is 12 bits wide, so keep this at 4096 or less
  parameter int THR_TICK_CYCLES = frb_pkg::THR_TICK_CYCLES // 22.5 kHz tick
) (
  input wire logic clk, // 50 MHz
  input wire logic rst_b, // synchronous, active low
  input wire logic [7:0] reg_addr, // register port from the serial logic
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] special_func_two, // special function control 2 value
  input wire logic regulator_hot_active, // high while regulator-hot asserted
  input wire logic processor_hot_active, // high while processor-hot seen
  input wire logic [3:0][7:0] zone_temp_raw, // signed degrees, zone 1 first
  input wire logic [1:0][7:0] zone_temp_filtered, // zones 1 and 2
  input wire logic [3:0][7:0] boost_temp, // signed boost thresholds
  output logic [3:0] ramp_step_regulator, // requested table step
  output logic [3:0] ramp_step_processor,
  output logic [3:0] boost_full, // zone holds fan at full duty
  output logic [1:0][7:0] zone_temp_control, // for limit check and fan control
  output logic [1:0][6:0] smooth_window_ds, // window in tenths of seconds
  output logic [1:0][3:0] table_hyst, // pair a in [0]
  output logic [1:0] table_hyst_half_deg, // half degree resolution
  output logic [1:0][3:0] min_duty, // minimum duty code per pair
  output logic [1:0] min_duty_mapped, // code maps to a duty
  output logic [7:0] gpio_o, // open-drain pin level when driven
  output logic [7:0] gpio_oe,
  output logic processor_hot_o,
  output logic processor_hot_oe, // pulls processor-hot pin low
  output logic [7:0] low_threshold_sel // per-input lower levels
);
  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  frb_pkg::frb_state_s st; // present state
  frb_pkg::frb_state_s next_st; // next state

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // all behaviour in one process, state lands in one register
  always_comb begin
    logic tick_ramp; // one-cycle 50 ms enable
    logic tick_thr; // one-cycle 22.5 kHz enable
    logic [3:0] code; // ramp delay code
    logic hot; // ramp input level
    logic signed [9:0] t_eff; // temperature used by boost
    logic signed [9:0] t_boost; // boost threshold
    logic signed [9:0] t_release; // threshold less hysteresis
    logic [3:0] hyst; // zone hysteresis
    logic [6:0] on_ticks; // throttle asserted time
    logic thr_pwm; // forced throttle waveform
    logic [7:0] idx; // register index
    tick_ramp = 1'b0;
    tick_thr = 1'b0;
    code = 4'h0;
    hot = 1'b0;
    t_eff = 10'sh000;
    t_boost = 10'sh000;
    t_release = 10'sh000;
    hyst = 4'h0;
    on_ticks = 7'h00;
    thr_pwm = 1'b0;
    idx = reg_addr - frb_pkg::OFS_INPUT_LEVEL_SELECT;
    next_st = st;

    // register writes, every bit kept as written
    if (reg_wr && idx < 8'(frb_pkg::NUM_REGS)) begin
      next_st.regs[idx[3:0]] = reg_wdata;
    end
    // read data, unmapped offsets answer zero
    if (reg_rd) begin
      if (idx < 8'(frb_pkg::NUM_REGS)) begin
        next_st.rd_data = st.regs[idx[3:0]];
      end else begin
        next_st.rd_data = 8'h00;
      end
    end

    // 50 ms divider, shared by both ramps
    if (st.div_ramp == 22'(RAMP_UNIT_CYCLES - 1)) begin
      next_st.div_ramp = 22'h000000;
      tick_ramp = 1'b1;
    end else begin
      next_st.div_ramp = st.div_ramp + 22'h000001;
    end
    // 22.5 kHz divider for the throttle waveform
    if (st.div_thr == 12'(THR_TICK_CYCLES - 1)) begin
      next_st.div_thr = 12'h000;
      tick_thr = 1'b1;
    end else begin
      next_st.div_thr = st.div_thr + 12'h001;
    end

    // ramps: [0] regulator-hot, [1] processor-hot
    for (int r = 0; r < 2; r++) begin
      if (r == 0) begin
        code = st.regs[frb_pkg::IDX_RAMP][3:0];
        hot = regulator_hot_active;
      end else begin
        code = st.regs[frb_pkg::IDX_RAMP][7:4];
        hot = processor_hot_active;
      end
      if (code == 4'h0) begin
        // no delay: full at once, and off at once
        next_st.ramp_step[r] = hot ? frb_pkg::FULL_DUTY_STEP : 4'h0;
        next_st.ramp_cnt[r] = 4'h0;
      end else if (tick_ramp) begin
        // count code intervals of 50 ms before each step
        if (st.ramp_cnt[r] + 4'h1 >= code) begin
          next_st.ramp_cnt[r] = 4'h0;
          if (hot && st.ramp_step[r] < frb_pkg::FULL_DUTY_STEP) begin
            next_st.ramp_step[r] = st.ramp_step[r] + 4'h1;
          end else if (!hot && st.ramp_step[r] != 4'h0) begin
            next_st.ramp_step[r] = st.ramp_step[r] - 4'h1;
          end
        end else begin
          next_st.ramp_cnt[r] = st.ramp_cnt[r] + 4'h1;
        end
      end
    end

    // zones one and two choose raw or filtered temperature
    next_st.zone_eff[0] = st.regs[frb_pkg::IDX_SMOOTH][frb_pkg::BIT_SMOOTH_EN_ONE] ?
      zone_temp_filtered[0] : zone_temp_raw[0];
    next_st.zone_eff[1] = st.regs[frb_pkg::IDX_SMOOTH][frb_pkg::BIT_SMOOTH_EN_TWO] ?
      zone_temp_filtered[1] : zone_temp_raw[1];
    // raw readings are never replaced here; the reading path keeps them

    // boost latch per zone, release below threshold less hysteresis
    for (int z = 0; z < 4; z++) begin
      if (z < 2) begin
        t_eff = 10'(signed'(next_st.zone_eff[z[0]]));
      end else begin
        t_eff = 10'(signed'(zone_temp_raw[z]));
      end
      case (z)
        0: hyst = st.regs[frb_pkg::IDX_HYST12][3:0];
        1: hyst = st.regs[frb_pkg::IDX_HYST12][7:4];
        2: hyst = st.regs[frb_pkg::IDX_HYST34][3:0];
        default: hyst = st.regs[frb_pkg::IDX_HYST34][7:4];
      endcase
      t_boost = 10'(signed'(boost_temp[z]));
      t_release = t_boost - signed'({6'h00, hyst});
      if (t_eff > t_boost) begin
        next_st.boost[z] = 1'b1;
      end else if (t_eff < t_release) begin
        next_st.boost[z] = 1'b0;
      end
    end

    // smoothing window lengths
    next_st.window_ds[0] =
      frb_pkg::SMOOTH_WINDOW_DS[st.regs[frb_pkg::IDX_SMOOTH][2:0]];
    next_st.window_ds[1] =
      frb_pkg::SMOOTH_WINDOW_DS[st.regs[frb_pkg::IDX_SMOOTH][6:4]];

    // table hysteresis and minimum duty per pair
    next_st.tbl_hyst[0] = st.regs[frb_pkg::IDX_TBL_A][3:0];
    next_st.tbl_half[0] = special_func_two[frb_pkg::BIT_TBL_RES_A];
    next_st.tbl_hyst[1] = st.regs[frb_pkg::IDX_TBL_B][3:0];
    next_st.tbl_half[1] = special_func_two[frb_pkg::BIT_TBL_RES_B];
    next_st.min_duty[0] = st.regs[frb_pkg::IDX_TBL_A][7:4];
    next_st.min_duty[1] = st.regs[frb_pkg::IDX_TBL_B][7:4];
    // three codes carry no duty; the fan logic must not use them
    next_st.min_valid[0] = st.regs[frb_pkg::IDX_TBL_A][7:4] <= frb_pkg::MAX_MAPPED_CODE;
    next_st.min_valid[1] = st.regs[frb_pkg::IDX_TBL_B][7:4] <= frb_pkg::MAX_MAPPED_CODE;

    // open-drain outputs: set bit drives low, clear bit floats
    next_st.gpio_oe = st.regs[frb_pkg::IDX_GPO];

    // throttle waveform: 80 tick period
    if (tick_thr) begin
      if (st.thr_cnt == frb_pkg::THR_PERIOD_TICKS - 7'h01) begin
        next_st.thr_cnt = 7'h00;
      end else begin
        next_st.thr_cnt = st.thr_cnt + 7'h01;
      end
    end
    on_ticks = 7'(({3'h0, st.regs[frb_pkg::IDX_THROTTLE][3:0]} + 7'h01) *
      frb_pkg::THR_STEP_TICKS);
    thr_pwm = st.thr_cnt < on_ticks;
    // forced throttle, or regulator-hot unless blocked
    next_st.proc_hot_oe =
      (st.regs[frb_pkg::IDX_THROTTLE][frb_pkg::BIT_FORCE_THROTTLE] && thr_pwm) ||
      (regulator_hot_active &&
       !st.regs[frb_pkg::IDX_THROTTLE][frb_pkg::BIT_REG_TO_THR_DIS]);

    // input threshold selects, eight and nine gated by mode
    next_st.level_sel = st.regs[frb_pkg::IDX_LEVEL];
    next_st.level_sel[1] = 1'b0; // reserved position drives nothing
    if (special_func_two[7:6] != frb_pkg::VOLTAGE_ID_MODE_LEGACY_SIX) begin
      next_st.level_sel[3:2] = 2'h0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // synchronous reset, second assignment supplies register defaults
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      st.regs <= frb_pkg::REG_RESET;
      st.window_ds <= {2{frb_pkg::SMOOTH_WINDOW_DS[0]}};
      st.min_valid <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs, straight from the state register except the two pin levels tied low
  // ------------------------------------------------------------
  assign reg_rdata = st.rd_data;
  assign ramp_step_regulator = st.ramp_step[0];
  assign ramp_step_processor = st.ramp_step[1];
  assign boost_full = st.boost;
  assign zone_temp_control = st.zone_eff;
  assign smooth_window_ds = st.window_ds;
  assign table_hyst = st.tbl_hyst;
  assign table_hyst_half_deg = st.tbl_half;
  assign min_duty = st.min_duty;
  assign min_duty_mapped = st.min_valid;
  assign gpio_o = 8'h00; // open-drain: only ever drives low
  assign gpio_oe = st.gpio_oe;
  assign processor_hot_o = 1'b0;
  assign processor_hot_oe = st.proc_hot_oe;
  assign low_threshold_sel = st.level_sel;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_zero_code_hot;
    st.regs[frb_pkg::IDX_RAMP][3:0] == 4'h0 && regulator_hot_active;
  endsequence
  sequence s_force_on;
    st.regs[frb_pkg::IDX_THROTTLE][frb_pkg::BIT_FORCE_THROTTLE] && !regulator_hot_active;
  endsequence

  AST_RAMP_ZERO_JUMP: assert property (s_zero_code_hot |=>
    ramp_step_regulator == 4'hd) else $error("zero delay ramp did not jump to full");
  AST_RAMP_WAIT: assert property (
    st.regs[frb_pkg::IDX_RAMP][7:4] == 4'h2 && $stable(st.regs[frb_pkg::IDX_RAMP]) &&
    st.div_ramp == 22'(RAMP_UNIT_CYCLES - 1) && st.ramp_cnt[1] == 4'h0
    |=> $stable(ramp_step_processor)) else $error("ramp stepped before its interval");
  AST_RAMP_UP: assert property (
    st.regs[frb_pkg::IDX_RAMP][3:0] == 4'h1 && regulator_hot_active &&
    st.div_ramp == 22'(RAMP_UNIT_CYCLES - 1) && ramp_step_regulator < 4'hd
    |=> ramp_step_regulator == $past(ramp_step_regulator) + 4'h1)
    else $error("ramp did not step up");
  AST_BOOST_HOLD: assert property (
    boost_full[2] && $signed(zone_temp_raw[2]) >= $signed(boost_temp[2]) -
    $signed({4'h0, st.regs[frb_pkg::IDX_HYST34][3:0]}) |=> boost_full[2])
    else $error("boost released inside hysteresis");
  AST_BOOST_SET: assert property (
    $signed(zone_temp_raw[3]) > $signed(boost_temp[3]) |=> boost_full[3])
    else $error("boost not set above threshold");
  AST_SMOOTH_SEL: assert property (
    st.regs[frb_pkg::IDX_SMOOTH][frb_pkg::BIT_SMOOTH_EN_ONE]
    |=> zone_temp_control[0] == $past(zone_temp_filtered[0]))
    else $error("zone one not on filtered temperature");
  AST_THR_WRAP: assert property (
    st.thr_cnt == 7'h4f && st.div_thr == 12'(THR_TICK_CYCLES - 1)
    |=> st.thr_cnt == 7'h00) else $error("throttle period not 80 ticks");
  AST_THR_DUTY: assert property (
    s_force_on ##0 (st.regs[frb_pkg::IDX_THROTTLE][3:0] == 4'h0 && st.thr_cnt == 7'h05)
    |=> !processor_hot_oe) else $error("throttle asserted past its duty");
  AST_THR_BLOCK: assert property (
    st.regs[frb_pkg::IDX_THROTTLE][frb_pkg::BIT_REG_TO_THR_DIS] &&
    !st.regs[frb_pkg::IDX_THROTTLE][frb_pkg::BIT_FORCE_THROTTLE]
    |=> !processor_hot_oe) else $error("regulator-hot reached throttle while blocked");
  AST_GPO_PULL: assert property (
    reg_wr && reg_addr == frb_pkg::OFS_OPEN_DRAIN_OUTPUTS ##1 !reg_wr
    |=> gpio_oe == $past(reg_wdata, 2)) else $error("open-drain enable wrong");
  AST_LEVEL_GATE: assert property (
    special_func_two[7:6] != 2'h0 |=> low_threshold_sel[3:2] == 2'h0)
    else $error("inputs eight and nine levels outside legacy mode");
  AST_READBACK: assert property (
    reg_wr && reg_addr == frb_pkg::OFS_BOOST_HYST_ONE_TWO ##1 !reg_wr ##1
    (!reg_wr && reg_rd && reg_addr == frb_pkg::OFS_BOOST_HYST_ONE_TWO)
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("register read back differs");
  // ramp down, zero-delay processor ramp, the smoothing selects and the smoothing windows
  AST_RAMP_DOWN: assert property (
    st.regs[frb_pkg::IDX_RAMP][3:0] == 4'h1 && !regulator_hot_active &&
    st.div_ramp == 22'(RAMP_UNIT_CYCLES - 1) && ramp_step_regulator != 4'h0
    |=> ramp_step_regulator == $past(ramp_step_regulator) - 4'h1)
    else $error("ramp did not step down");
  AST_RAMP_PROC_ZERO: assert property (
    st.regs[frb_pkg::IDX_RAMP][7:4] == 4'h0 && processor_hot_active
    |=> ramp_step_processor == 4'hd) else $error("processor ramp did not jump to full");
  AST_SMOOTH_SEL_TWO: assert property (
    st.regs[frb_pkg::IDX_SMOOTH][frb_pkg::BIT_SMOOTH_EN_TWO]
    |=> zone_temp_control[1] == $past(zone_temp_filtered[1])) else $error("zone two not filtered");
  AST_RAW_WHEN_OFF: assert property (
    !st.regs[frb_pkg::IDX_SMOOTH][frb_pkg::BIT_SMOOTH_EN_ONE]
    |=> zone_temp_control[0] == $past(zone_temp_raw[0])) else $error("zone one not raw");
  AST_WINDOW_ONE: assert property (st.regs[frb_pkg::IDX_SMOOTH][2:0] == 3'h0
    |=> smooth_window_ds[0] == 7'h76) else $error("zone one window wrong");
  AST_WINDOW_TWO: assert property (st.regs[frb_pkg::IDX_SMOOTH][6:4] == 3'h7
    |=> smooth_window_ds[1] == 7'h04) else $error("zone two window wrong");
  // table resolution follows the special function bits one cycle late
  AST_TBL_RES: assert property (1'b1
    |=> table_hyst_half_deg == $past(special_func_two[5:4])) else $error("resolution wrong");
  AST_TBL_HYST_B: assert property (1'b1
    |=> table_hyst[1] == $past(st.regs[frb_pkg::IDX_TBL_B][3:0]))
    else $error("pair b hysteresis wrong");
  AST_MIN_UNMAPPED: assert property (st.regs[frb_pkg::IDX_TBL_A][7:4] > 4'hc
    |=> !min_duty_mapped[0]) else $error("unmapped minimum duty flagged mapped");
  AST_LEVEL_LEGACY: assert property (
    special_func_two[7:6] == 2'h0 && st.regs[frb_pkg::IDX_LEVEL][2]
    |=> low_threshold_sel[2]) else $error("input eight level lost in legacy mode");
  AST_THR_FULL: assert property (s_force_on ##0 st.regs[frb_pkg::IDX_THROTTLE][3:0] == 4'hf
    |=> processor_hot_oe) else $error("full throttle code released");
  AST_REG_TO_THR: assert property (
    regulator_hot_active && !st.regs[frb_pkg::IDX_THROTTLE][frb_pkg::BIT_REG_TO_THR_DIS]
    |=> processor_hot_oe) else $error("regulator-hot did not reach throttle");
endmodule

// ---- frb_pkg.sv ----
// constants and types shared by the fan ramp and boost setup bank
package frb_pkg;
  // ------------------------------------------------------------
  // register map (byte offsets on the internal register port)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_INPUT_LEVEL_SELECT = 8'hbe; // first register of the bank
  localparam logic [7:0] OFS_PWM_RAMP_DELAYS = 8'hbf;
  localparam logic [7:0] OFS_BOOST_HYST_ONE_TWO = 8'hc0;
  localparam logic [7:0] OFS_BOOST_HYST_THREE_FOUR = 8'hc1;
  localparam logic [7:0] OFS_SPIKE_SMOOTHING = 8'hc2;
  localparam logic [7:0] OFS_TABLE_PAIR_A = 8'hc3;
  localparam logic [7:0] OFS_TABLE_PAIR_B = 8'hc4;
  localparam logic [7:0] OFS_OPEN_DRAIN_OUTPUTS = 8'hc5;
  localparam logic [7:0] OFS_THROTTLE_FORCE = 8'hc6; // last register of the bank
  localparam int NUM_REGS = 9;
  // register indices, offset minus the first offset
  localparam int IDX_LEVEL = 0;
  localparam int IDX_RAMP = 1;
  localparam int IDX_HYST12 = 2;
  localparam int IDX_HYST34 = 3;
  localparam int IDX_SMOOTH = 4;
  localparam int IDX_TBL_A = 5;
  localparam int IDX_TBL_B = 6;
  localparam int IDX_GPO = 7;
  localparam int IDX_THROTTLE = 8;
  // values after reset, index 8 down to 0
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h44, 8'h00, 8'h00};
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_SMOOTH_EN_ONE = 3;
  localparam int BIT_SMOOTH_EN_TWO = 7;
  localparam int BIT_REG_TO_THR_DIS = 4;
  localparam int BIT_FORCE_THROTTLE = 6;
  localparam int BIT_TBL_RES_A = 4; // in special function control 2
  localparam int BIT_TBL_RES_B = 5;
  localparam logic [1:0] VOLTAGE_ID_MODE_LEGACY_SIX = 2'h0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int RAMP_UNIT_MS = 50;
  localparam int RAMP_UNIT_CYCLES = (CLK_HZ / 1000) * RAMP_UNIT_MS;
  localparam int THR_TICK_HZ = 22_500;
  localparam int THR_TICK_CYCLES = CLK_HZ / THR_TICK_HZ; // rounded down
  localparam logic [6:0] THR_PERIOD_TICKS = 7'h50; // 80 ticks
  localparam logic [6:0] THR_STEP_TICKS = 7'h05;
  localparam logic [3:0] FULL_DUTY_STEP = 4'hd; // table step 13
  localparam logic [3:0] MAX_MAPPED_CODE = 4'hc; // codes 0..12 carry a duty
  // smoothing windows in tenths of a second, code 7 down to 0
  localparam logic [7:0][6:0] SMOOTH_WINDOW_DS = {
    7'h04, 7'h06, 7'h08, 7'h10, 7'h1e, 7'h2c, 7'h46, 7'h76};
  // ------------------------------------------------------------
  // whole state of the bank
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0] rd_data;
    logic [21:0] div_ramp;
    logic [11:0] div_thr;
    logic [1:0][3:0] ramp_cnt;
    logic [1:0][3:0] ramp_step;
    logic [3:0] boost;
    logic [1:0][7:0] zone_eff;
    logic [1:0][6:0] window_ds;
    logic [6:0] thr_cnt;
    logic proc_hot_oe;
    logic [7:0] gpio_oe;
    logic [7:0] level_sel;
    logic [1:0][3:0] tbl_hyst;
    logic [1:0] tbl_half;
    logic [1:0][3:0] min_duty;
    logic [1:0] min_valid;
  } frb_state_s;
endpackage

// ---- frb_bank_tb.sv ----
// self-checking testbench for the fan ramp and boost setup bank
`timescale 1ns/100ps
module testbench;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0; // 50 MHz
  logic rst_b = 1'b0; // held low for two edges
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] special_func_two = 8'h00; // voltage_id_mode legacy at start
  logic regulator_hot_active = 1'b0, processor_hot_active = 1'b0;
  logic [3:0][7:0] zone_temp_raw = 32'h1a2b3c4d, boost_temp = 32'h32323232;
  logic [1:0][7:0] zone_temp_filtered = 16'h5e6f, zone_temp_control;
  logic [3:0] ramp_step_regulator, ramp_step_processor, boost_full;
  logic [1:0][6:0] smooth_window_ds;
  logic [1:0][3:0] table_hyst, min_duty;
  logic [1:0] table_hyst_half_deg, min_duty_mapped;
  logic [7:0] gpio_o, gpio_oe, low_threshold_sel;
  logic processor_hot_o, processor_hot_oe;
  int error_cnt = 0, total_checks = 0;
  int highs; // throttle asserted-cycle counter
  // ------------------------------------------------------------
  // ordinary write and read-back rows
  // ------------------------------------------------------------
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} frb_tb_row_s;
  // reserved bits included, last two offsets are unmapped
  localparam frb_tb_row_s ROWS [11] = '{
    '{8'hbe, 8'hff, 8'hff}, '{8'hbf, 8'ha5, 8'ha5}, '{8'hc0, 8'h5a, 8'h5a},
    '{8'hc1, 8'hc3, 8'hc3}, '{8'hc2, 8'h7e, 8'h7e}, '{8'hc3, 8'h96, 8'h96},
    '{8'hc4, 8'h69, 8'h69}, '{8'hc5, 8'h3c, 8'h3c}, '{8'hc6, 8'hb7, 8'hb7},
    '{8'hc7, 8'h55, 8'h00}, '{8'hbd, 8'haa, 8'h00}};
  localparam logic [7:0] DEFS [9] = '{8'h00, 8'h00, 8'h44, 8'h44, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00}; // offsets be..c6
  // smoothing windows in tenths of a second, code 0 first
  localparam logic [7:0] WIN [8] = '{8'h76, 8'h46, 8'h2c, 8'h1e, 8'h10, 8'h08, 8'h06, 8'h04};
  // ------------------------------------------------------------
  // clock and design under test
  // ------------------------------------------------------------
  always #10 clk = ~clk; // 20 ns period
  // short ramp unit and throttle tick: ramps take hundreds of cycles, periods 800
  frb_bank #(.RAMP_UNIT_CYCLES(10), .THR_TICK_CYCLES(10)) frb_bank_inst (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_func_two(special_func_two),
    .regulator_hot_active(regulator_hot_active), .processor_hot_active(processor_hot_active),
    .zone_temp_raw(zone_temp_raw), .zone_temp_filtered(zone_temp_filtered),
    .boost_temp(boost_temp), .ramp_step_regulator(ramp_step_regulator),
    .ramp_step_processor(ramp_step_processor), .boost_full(boost_full),
    .zone_temp_control(zone_temp_control), .smooth_window_ds(smooth_window_ds),
    .table_hyst(table_hyst), .table_hyst_half_deg(table_hyst_half_deg), .min_duty(min_duty),
    .min_duty_mapped(min_duty_mapped), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .processor_hot_o(processor_hot_o), .processor_hot_oe(processor_hot_oe),
    .low_threshold_sel(low_threshold_sel));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe, launched after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read strobe, data sampled one cycle after it is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk(reg_rdata, exp);
  endtask
  // waits n edges and lets their updates land
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // derived outputs follow a write two cycles later
  task automatic settle;
    cycles(3);
  endtask
  task automatic set_temps(input logic [3:0][7:0] t);
    @(posedge clk);
    zone_temp_raw <= t;
    settle();
  endtask
  task automatic set_hot(input logic h);
    @(posedge clk);
    regulator_hot_active <= h;
    processor_hot_active <= h;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog, about five times the expected run
  // ------------------------------------------------------------
  initial begin
    #(20000 * 20);
    error_cnt++;
    results();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'hbe + 8'(i), DEFS[i]);
    for (int i = 0; i < 11; i++) begin
      wr(ROWS[i].addr, ROWS[i].wdata);
      rd(ROWS[i].addr, ROWS[i].exp);
    end
    // boost: zone hysteresis 1, 2, 3, 4, raw temps for zones 1/2
    wr(8'hc2, 8'h00);
    wr(8'hc0, 8'h21);
    wr(8'hc1, 8'h43);
    set_temps(32'h20202020); // far below every release point
    chk({4'h0, boost_full}, 8'h00);
    set_temps(32'h32323232);
    chk({4'h0, boost_full}, 8'h00);
    set_temps(32'h33333333);
    chk({4'h0, boost_full}, 8'h0f);
    set_temps(32'h2e2f3031); // exactly boost minus hysteresis: still held
    chk({4'h0, boost_full}, 8'h0f);
    set_temps(32'h2d2e2f30);
    chk({4'h0, boost_full}, 8'h00);
    // smoothing windows and enables, every code on both zones
    for (int i = 0; i < 8; i++) begin
      wr(8'hc2, {i[0], 3'(7 - i), i[1], 3'(i)});
      settle();
      chk({1'b0, smooth_window_ds[0]}, WIN[i]);
      chk({1'b0, smooth_window_ds[1]}, WIN[7 - i]);
      chk(zone_temp_control[0], i[1] ? zone_temp_filtered[0] : zone_temp_raw[0]);
      chk(zone_temp_control[1], i[0] ? zone_temp_filtered[1] : zone_temp_raw[1]);
    end
    // ramps: regulator code 1, processor code 2
    wr(8'hbf, 8'h21);
    set_hot(1'b1);
    cycles(100);
    chk({7'h0, ramp_step_processor < ramp_step_regulator}, 8'h01);
    chk({7'h0, ramp_step_regulator > 4'h7 && ramp_step_regulator < 4'hd}, 8'h01);
    cycles(200);
    chk({ramp_step_processor, ramp_step_regulator}, 8'hdd);
    set_hot(1'b0);
    cycles(300);
    chk({ramp_step_processor, ramp_step_regulator}, 8'h00);
    wr(8'hbf, 8'h00); // zero delay jumps straight to full
    set_hot(1'b1);
    settle();
    chk({ramp_step_processor, ramp_step_regulator}, 8'hdd);
    set_hot(1'b0);
    settle();
    // level selects in legacy mode then in another voltage_id_mode
    @(posedge clk);
    special_func_two <= 8'h10;
    wr(8'hbe, 8'hff);
    settle();
    chk(low_threshold_sel, 8'hfd);
    @(posedge clk);
    special_func_two <= 8'h50;
    settle();
    chk(low_threshold_sel, 8'hf1);
    // table pairs: code 13 unmapped, code 12 mapped
    wr(8'hc3, 8'hd5);
    wr(8'hc4, 8'hc7);
    settle();
    chk({table_hyst[1], table_hyst[0]}, 8'h75);
    chk({min_duty[1], min_duty[0]}, 8'hcd);
    chk({4'h0, table_hyst_half_deg, min_duty_mapped}, 8'h06);
    wr(8'hc5, 8'ha5);
    settle();
    chk(gpio_oe, 8'ha5);
    chk(gpio_o, 8'h00);
    wr(8'hc5, 8'h00); // pins used as inputs keep their bits clear
    settle();
    chk(gpio_oe, 8'h00);
    // forced throttle: asserted cycles over two whole 800-cycle periods
    wr(8'hc6, 8'h4f);
    settle();
    highs = 0;
    repeat (1600) begin
      cycles(1);
      if (processor_hot_oe === 1'b1) highs++;
    end
    chk({7'h0, highs == 1600}, 8'h01);
    wr(8'hc6, 8'h40);
    settle();
    highs = 0;
    repeat (1600) begin
      cycles(1);
      if (processor_hot_oe === 1'b1) highs++;
    end
    chk({7'h0, highs == 100}, 8'h01);
    // regulator-hot drives processor-hot unless disabled
    wr(8'hc6, 8'h00);
    @(posedge clk);
    regulator_hot_active <= 1'b1;
    settle();
    chk({processor_hot_o, processor_hot_oe}, 8'h01);
    wr(8'hc6, 8'h10);
    settle();
    chk({processor_hot_o, processor_hot_oe}, 8'h00);
    // second reset in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    cycles(2);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(8'hc0, 8'h44);
    chk(gpio_oe, 8'h00);
    results();
  end
endmodule
